// ### rtl/timer_pkg.sv
// shared constants, register layouts and types for the prescaled timer
package timer_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_COUNT_LOW = 12'h59C;
  localparam logic [11:0] IDX_PERIOD_HIGH = 12'h59D;
  localparam logic [11:0] IDX_CTRL_FIRST = 12'h59E;
  localparam logic [11:0] IDX_CTRL_SECOND = 12'h59F;
  localparam logic [11:0] IDX_IRQ_CTRL = 12'h5A0;
  localparam int unsigned ADDR_LSB = 2;

  // widths
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned PRESCALE_W = 15;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned SRC_N = 6;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] POST_RST = 4'h0;

  // interrupt control register bit positions
  localparam int unsigned IRQ_FLAG_BIT = 0;
  localparam int unsigned IRQ_EN_BIT = 1;

  // instruction clock is a quarter of the system clock
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  // positions of the asynchronous clock inputs in the sync vector
  localparam int unsigned SRC_IDX_PIN = 0;
  localparam int unsigned SRC_IDX_HF = 1;
  localparam int unsigned SRC_IDX_LF = 2;
  localparam int unsigned SRC_IDX_MF = 3;
  localparam int unsigned SRC_IDX_SOSC = 4;
  localparam int unsigned SRC_IDX_CLC = 5;

  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    SRC_PIN = 3'h0,
    SRC_PIN_INV = 3'h1,
    SRC_INSTR = 3'h2,
    SRC_HFINT = 3'h3,
    SRC_LFINT = 3'h4,
    SRC_MFINT = 3'h5,
    SRC_SOSC = 3'h6,
    SRC_CLC1 = 3'h7
  } clk_src_e;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRITE = 3'h2,
    BUS_READ = 3'h4
  } bus_state_e;

  typedef struct packed {
    logic module_enable_bit;
    logic unused_bit;
    logic output_status_bit;
    logic wide_count_select;
    logic [3:0] postscale_select;
  } ctrl_first_s;

  typedef struct packed {
    logic [2:0] clock_source_select;
    logic async_count_enable;
    logic [3:0] prescale_select;
  } ctrl_second_s;

endpackage : timer_pkg

// ### rtl/prescale_div.sv
// input prescaler: passes one tick out of two to the power of sel
`timescale 1ns/1ns
module prescale_div
  import timer_pkg::*;
#(
  parameter int unsigned DIV_W = PRESCALE_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [SEL_W-1:0] sel,
  output logic pulse
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;
  logic pulse_q;

  // low sel bits of the counter must all be ones to pass a tick
  assign mask = DIV_W'((32'h1 << sel) - 32'h1); // see [RL14]
  assign pulse = pulse_q;

  // counter is invisible to software, only cleared by writes and reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else if (clear) begin
      div_q <= '0; // see [RL15]
    end else if (tick) begin
      div_q <= div_q + DIV_W'(1); // see [RL13]
    end
  end

  // registered pulse, one cycle behind the tick that caused it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= !clear && tick && ((div_q & mask) == mask);
    end
  end

  property p_div_one_passes;
    @(posedge clk) disable iff (!nrst)
    (sel == 4'h0) && tick && !clear |=> pulse_q;
  endproperty
  a_div_one_passes: assert property (p_div_one_passes) // see [RL14]
    else $error("prescaler 1:1 dropped a tick");

  property p_clear_zeroes;
    @(posedge clk) disable iff (!nrst)
    clear |=> (div_q == '0) && !pulse_q;
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) // see [RL15]
    else $error("prescaler not cleared");

endmodule : prescale_div

// ### rtl/timer_core.sv
// timer with prescaler, postscaler and an ahb-lite register slave
//
// Behaviour
// [RL1] counter runs 8 bits wide or 16 bits wide by the width select bit
// [RL2] counter advances on each rising edge of the prescaled selected clock
// [RL3] 8-bit: low byte compared with buffered period, cleared to zero on match
// [RL4] 8-bit: period buffer reloaded from period byte on each match
// [RL5] 16-bit: reading low byte latches the live high byte for software
// [RL6] 16-bit: high byte write buffered, applied when low byte is written
// [RL7] 16-bit: counter wraps from all ones to zero and keeps running
// [RL8] 16-bit: no automatic reload value once counting has started
// [RL9] clock source picked by three-bit field of second control register
// [RL10] source codes: pin, inverted pin, instr, hf, lf, mf, secondary, logic
// [RL11] async bit clear: clock synchronised to instruction clock, rate capped
// [RL12] async bit set: count on each source or prescaler edge unsynchronised; here the edges still pass the two-flop synchroniser
// [RL13] prescaler offers sixteen ratios from 1:1 to 1:32768
// [RL14] prescale code n divides the input clock by two to the n
// [RL15] prescaler hidden; cleared by low byte write, control write, reset
// [RL16] postscaler divides match or rollover events by 1 to 16
// [RL17] postscaler hidden; cleared by low byte write, control write, reset
// [RL18] output toggles on scaled period match or scaled 16-bit rollover
// [RL19] output drives a pin route and reads back as a status bit
// [RL20] interrupt flag set on every output toggle, irq when enabled
// [RL21] flag set once per postscale code plus one events
// [RL22] synchronous mode stops counting during sleep
// [RL23] asynchronous mode counts in sleep and wakes device when enabled
// [RL24] module enable bit set runs the timer, clear disables it
// [RL25] disabled: counter, scalers, output and flag hold their state
`timescale 1ns/1ns
module timer_core
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_clk_pin,
  input wire logic hfintosc_clk,
  input wire logic lfintosc_clk,
  input wire logic mfintosc_clk,
  input wire logic sosc_clk,
  input wire logic clc1_out,
  input wire logic sleep_mode,
  output logic timer_output_signal,
  output logic cpu_irq,
  output logic sleep_wake
);

  // word address compare against a register index
  function automatic logic reg_hit(input logic [31:0] addr, input logic [11:0] idx);
    reg_hit = (addr == (32'(idx) << ADDR_LSB));
  endfunction : reg_hit

  // edge of the selected clock source
  function automatic logic pick_edge(input logic [2:0] cs, input logic [SRC_N-1:0] rise,
                                     input logic [SRC_N-1:0] fall, input logic instr);
    case (clk_src_e'(cs))
      SRC_PIN: pick_edge = rise[SRC_IDX_PIN];
      SRC_PIN_INV: pick_edge = fall[SRC_IDX_PIN];
      SRC_INSTR: pick_edge = instr;
      SRC_HFINT: pick_edge = rise[SRC_IDX_HF];
      SRC_LFINT: pick_edge = rise[SRC_IDX_LF];
      SRC_MFINT: pick_edge = rise[SRC_IDX_MF];
      SRC_SOSC: pick_edge = rise[SRC_IDX_SOSC];
      SRC_CLC1: pick_edge = rise[SRC_IDX_CLC];
      default: pick_edge = 1'b0;
    endcase
  endfunction : pick_edge

  bus_state_e state_q;
  bus_state_e state_d;
  logic [31:0] addr_q;
  logic addr_ok;
  logic ready_d;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic [7:0] read_byte;
  logic wr_phase;
  logic rd_phase;
  logic wr_lo;
  logic wr_hi;
  logic wr_c0;
  logic wr_c1;
  logic wr_irq;
  logic rd_lo;
  logic ctrl_clear;

  ctrl_first_s ctrl0_q;
  ctrl_second_s ctrl1_q;
  logic [COUNT_W-1:0] cnt_lo_q;
  logic [COUNT_W-1:0] cnt_hi_q;
  logic [COUNT_W-1:0] high_reg_q;
  logic [COUNT_W-1:0] pbuf_q;
  logic [SEL_W-1:0] post_cnt_q;
  logic out_q;
  logic flag_q;
  logic ie_q;
  logic cpu_irq_q;
  logic wake_q;

  logic [SRC_N-1:0] src_raw;
  logic [SRC_N-1:0] sync1_q;
  logic [SRC_N-1:0] sync2_q;
  logic [SRC_N-1:0] prev_q;
  logic [SRC_N-1:0] rise;
  logic [SRC_N-1:0] fall;
  logic [1:0] div_q;
  logic instr_en_q;
  logic pend_q;
  logic sel_edge;
  logic sync_tick;
  logic raw_tick;
  logic cnt_pulse;
  logic count_now;
  logic match;
  logic rollover;
  logic timer_event;
  logic out_toggle;

  // bus slave: writes take no wait state, reads take one
  assign addr_ok = hsel && htrans[1] && hready;
  always_comb begin
    state_d = BUS_IDLE;
    ready_d = 1'b1;
    case (state_q)
      BUS_READ: begin
        state_d = BUS_IDLE; // hready low here, so no new address phase
      end
      BUS_IDLE, BUS_WRITE: begin
        if (addr_ok && hwrite) begin
          state_d = BUS_WRITE;
        end else if (addr_ok) begin
          state_d = BUS_READ;
          ready_d = 1'b0;
        end
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= BUS_IDLE;
      hreadyout_q <= 1'b1;
      addr_q <= 32'h0;
    end else begin
      state_q <= state_d;
      hreadyout_q <= ready_d;
      if (addr_ok) begin
        addr_q <= haddr;
      end
    end
  end

  // data phase strobes; unmapped addresses simply match nothing
  assign wr_phase = (state_q == BUS_WRITE);
  assign rd_phase = (state_q == BUS_READ);
  assign wr_lo = wr_phase && reg_hit(addr_q, IDX_COUNT_LOW);
  assign wr_hi = wr_phase && reg_hit(addr_q, IDX_PERIOD_HIGH);
  assign wr_c0 = wr_phase && reg_hit(addr_q, IDX_CTRL_FIRST);
  assign wr_c1 = wr_phase && reg_hit(addr_q, IDX_CTRL_SECOND);
  assign wr_irq = wr_phase && reg_hit(addr_q, IDX_IRQ_CTRL);
  assign rd_lo = rd_phase && reg_hit(addr_q, IDX_COUNT_LOW);
  assign ctrl_clear = wr_lo || wr_c0 || wr_c1; // see [RL15] [RL17]

  // read mux, sampled in the wait cycle so a preceding write is visible
  always_comb begin
    read_byte = BYTE_RST;
    if (reg_hit(addr_q, IDX_COUNT_LOW)) begin
      read_byte = cnt_lo_q;
    end else if (reg_hit(addr_q, IDX_PERIOD_HIGH)) begin
      read_byte = high_reg_q;
    end else if (reg_hit(addr_q, IDX_CTRL_FIRST)) begin
      read_byte = {ctrl0_q.module_enable_bit, 1'b0, out_q, ctrl0_q.wide_count_select,
                   ctrl0_q.postscale_select}; // see [RL19]
    end else if (reg_hit(addr_q, IDX_CTRL_SECOND)) begin
      read_byte = ctrl1_q;
    end else if (reg_hit(addr_q, IDX_IRQ_CTRL)) begin
      read_byte = {6'h0, ie_q, flag_q};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= 32'h0;
    end else if (rd_phase) begin
      hrdata_q <= {24'h0, read_byte};
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = HRESP_OKAY;

  // control registers; output status bit is read-only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl0_q <= ctrl_first_s'(BYTE_RST);
      ctrl1_q <= ctrl_second_s'(BYTE_RST);
    end else begin
      if (wr_c0) begin
        ctrl0_q <= ctrl_first_s'({hwdata[7], 2'h0, hwdata[4:0]});
      end
      if (wr_c1) begin
        ctrl1_q <= ctrl_second_s'(hwdata[7:0]);
      end
    end
  end

  // two-flop synchronisers for every clock source arriving from outside
  assign src_raw = {clc1_out, sosc_clk, mfintosc_clk, lfintosc_clk, hfintosc_clk, ext_clk_pin};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= src_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // instruction clock enable, one pulse every fourth system clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 2'h0;
      instr_en_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      instr_en_q <= (div_q == INSTR_DIV_LAST);
    end
  end

  assign sel_edge = pick_edge(ctrl1_q.clock_source_select, rise, fall,
                              instr_en_q); // see [RL9] [RL10]

  // synchronous mode holds an edge until the next instruction clock,
  // so at most one count per instruction cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (ctrl_clear || !ctrl0_q.module_enable_bit) begin
      pend_q <= 1'b0;
    end else if (sel_edge && !instr_en_q) begin
      pend_q <= 1'b1;
    end else if (instr_en_q) begin
      pend_q <= 1'b0;
    end
  end
  assign sync_tick = instr_en_q && (pend_q || sel_edge) && !sleep_mode; // see [RL11] [RL22]

  // only one clock exists here, so async edges still pass the synchroniser
  assign raw_tick = ctrl0_q.module_enable_bit && !ctrl_clear &&
                    (ctrl1_q.async_count_enable ? sel_edge : sync_tick); // see [RL12] [RL24]

  prescale_div #(
    .DIV_W(PRESCALE_W)
  ) prescale_div_i (
    .clk(clk),
    .nrst(nrst),
    .clear(ctrl_clear),
    .tick(raw_tick),
    .sel(ctrl1_q.prescale_select),
    .pulse(cnt_pulse)
  );

  // count decisions; a low byte write wins over a count in the same cycle
  assign count_now = cnt_pulse && ctrl0_q.module_enable_bit && !wr_lo; // see [RL2] [RL25]
  assign match = count_now && !ctrl0_q.wide_count_select && (cnt_lo_q == pbuf_q);
  assign rollover = count_now && ctrl0_q.wide_count_select &&
                    ({cnt_hi_q, cnt_lo_q} == 16'hFFFF);
  assign timer_event = match || rollover;

  // counter bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_lo_q <= BYTE_RST;
      cnt_hi_q <= BYTE_RST;
    end else if (wr_lo) begin
      cnt_lo_q <= hwdata[7:0];
      if (ctrl0_q.wide_count_select) begin
        cnt_hi_q <= high_reg_q; // see [RL6]
      end
    end else if (count_now) begin
      if (ctrl0_q.wide_count_select) begin
        // free running, wraps naturally, never reloaded from a period
        {cnt_hi_q, cnt_lo_q} <= {cnt_hi_q, cnt_lo_q} + 16'h0001; // see [RL1] [RL7] [RL8]
      end else if (match) begin
        cnt_lo_q <= BYTE_RST; // see [RL3]
      end else begin
        cnt_lo_q <= cnt_lo_q + 8'h01;
      end
    end
  end

  // software high byte: period in 8-bit width, holding buffer in 16-bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_reg_q <= BYTE_RST;
    end else if (wr_hi) begin
      high_reg_q <= hwdata[7:0];
    end else if (rd_lo && ctrl0_q.wide_count_select) begin
      high_reg_q <= cnt_hi_q; // see [RL5]
    end
  end

  // period buffer, new period only takes effect after a match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pbuf_q <= BYTE_RST;
    end else if (match) begin
      pbuf_q <= high_reg_q; // see [RL4]
    end
  end

  // postscaler and output toggle; a clearing write drops the event
  assign out_toggle = timer_event && !ctrl_clear &&
                      (post_cnt_q == ctrl0_q.postscale_select); // see [RL21]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      post_cnt_q <= POST_RST;
    end else if (ctrl_clear) begin
      post_cnt_q <= POST_RST; // see [RL17]
    end else if (timer_event) begin
      post_cnt_q <= out_toggle ? POST_RST : post_cnt_q + 4'h1; // see [RL16]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= 1'b0;
    end else if (out_toggle) begin
      out_q <= !out_q; // see [RL18] [RL19]
    end
  end

  // interrupt flag and enable; hardware set beats a software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      if (out_toggle) begin
        flag_q <= 1'b1; // see [RL20]
      end else if (wr_irq) begin
        flag_q <= hwdata[IRQ_FLAG_BIT];
      end
      if (wr_irq) begin
        ie_q <= hwdata[IRQ_EN_BIT];
      end
    end
  end

  // processor interrupt and sleep wake, both registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      cpu_irq_q <= flag_q && ie_q; // see [RL20]
      wake_q <= flag_q && ie_q && sleep_mode && ctrl1_q.async_count_enable; // see [RL23]
    end
  end

  assign timer_output_signal = out_q;
  assign cpu_irq = cpu_irq_q;
  assign sleep_wake = wake_q;

  property p_match_clears;
    @(posedge clk) disable iff (!nrst)
    match |=> (cnt_lo_q == 8'h00);
  endproperty
  a_match_clears: assert property (p_match_clears) // see [RL3]
    else $error("low byte not cleared on period match");

  property p_period_reload;
    @(posedge clk) disable iff (!nrst)
    match |=> (pbuf_q == $past(high_reg_q));
  endproperty
  a_period_reload: assert property (p_period_reload) // see [RL4]
    else $error("period buffer not reloaded on match");

  property p_wide_wrap;
    @(posedge clk) disable iff (!nrst)
    rollover |=> ({cnt_hi_q, cnt_lo_q} == 16'h0000) ##1 !rollover;
  endproperty
  a_wide_wrap: assert property (p_wide_wrap) // see [RL7]
    else $error("16-bit counter did not wrap to zero");

  property p_wide_step;
    @(posedge clk) disable iff (!nrst)
    count_now && ctrl0_q.wide_count_select && !rollover
      |=> ({cnt_hi_q, cnt_lo_q} == $past({cnt_hi_q, cnt_lo_q}) + 16'h0001);
  endproperty
  a_wide_step: assert property (p_wide_step) // see [RL2]
    else $error("16-bit counter did not step by one");

  property p_read_latch;
    @(posedge clk) disable iff (!nrst)
    rd_lo && ctrl0_q.wide_count_select |=> (high_reg_q == $past(cnt_hi_q));
  endproperty
  a_read_latch: assert property (p_read_latch) // see [RL5]
    else $error("low byte read did not latch high byte");

  property p_write_pair;
    @(posedge clk) disable iff (!nrst)
    wr_lo && ctrl0_q.wide_count_select
      |=> (cnt_hi_q == $past(high_reg_q)) && (cnt_lo_q == $past(hwdata[7:0]));
  endproperty
  a_write_pair: assert property (p_write_pair) // see [RL6]
    else $error("16-bit write did not update both bytes");

  property p_post_hold;
    @(posedge clk) disable iff (!nrst)
    timer_event && (post_cnt_q != ctrl0_q.postscale_select) |=> $stable(out_q);
  endproperty
  a_post_hold: assert property (p_post_hold) // see [RL21]
    else $error("output toggled before postscale count reached");

  property p_flag_on_toggle;
    @(posedge clk) disable iff (!nrst)
    out_toggle |=> flag_q && (out_q != $past(out_q));
  endproperty
  a_flag_on_toggle: assert property (p_flag_on_toggle) // see [RL20]
    else $error("flag not set on output toggle");

  property p_disabled_holds;
    @(posedge clk) disable iff (!nrst)
    !ctrl0_q.module_enable_bit && !wr_lo |=> $stable(cnt_lo_q) && $stable(out_q);
  endproperty
  a_disabled_holds: assert property (p_disabled_holds) // see [RL25]
    else $error("disabled timer changed state");

  property p_sleep_stops;
    @(posedge clk) disable iff (!nrst)
    sleep_mode && $past(sleep_mode) && !ctrl1_q.async_count_enable &&
      !$past(ctrl1_q.async_count_enable) && !$past(wr_c1) |-> !cnt_pulse;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) // see [RL22]
    else $error("synchronous timer counted in sleep");

  property p_wake;
    @(posedge clk) disable iff (!nrst)
    flag_q && ie_q && sleep_mode && ctrl1_q.async_count_enable |=> sleep_wake;
  endproperty
  a_wake: assert property (p_wake) // see [RL23]
    else $error("no wake from sleep on enabled flag");

endmodule : timer_core

// ### verif/timer_with_prescale_postscale_test.sv
// self-checking bench for the prescaled timer with its register slave
`timescale 1ns/1ns
module timer_with_prescale_postscale_test;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [5:0] src = 6'h00;
  logic sleep = 1'b0;
  logic tout;
  logic irq;
  logic wake;
  int n_mismatch = 0;
  int comparisons = 0;
  // bench copy of the timer state, advanced per effective source edge
  logic [15:0] cnt = 16'h0;
  logic [7:0] hbuf = 8'h00;
  logic [7:0] buf8 = 8'h00;
  logic [3:0] psel = 4'h0;
  logic [3:0] osel = 4'h0;
  logic [3:0] post = 4'h0;
  logic [2:0] code = 3'h0;
  logic en = 1'b0;
  logic wide = 1'b0;
  logic asy = 1'b0;
  logic ie = 1'b0;
  logic flag = 1'b0;
  logic out = 1'b0;
  logic [7:0] q;
  int pre = 0;

  always #4 clk = ~clk;

  timer_core timer_core_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clk_pin(src[0]),
    .hfintosc_clk(src[1]), .lfintosc_clk(src[2]), .mfintosc_clk(src[3]), .sosc_clk(src[4]),
    .clc1_out(src[5]), .sleep_mode(sleep), .timer_output_signal(tout), .cpu_irq(irq),
    .sleep_wake(wake));

  task give_verdict;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one ahb-lite single transfer; waits are bounded, a hang ends the run
  task bus(input logic [11:0] idx, input logic w, input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata[7:0];
    chk("response", 16'h0000, {15'h0, hresp});
    if (n >= 100) begin
      n_mismatch++;
      give_verdict;
    end
  endtask : bus

  // write a register and mirror its side effects in the bench copy
  task wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(idx, 1'b1, d, r);
    case (idx)
      IDX_COUNT_LOW: begin
        cnt[7:0] = d;
        if (wide) cnt[15:8] = hbuf;
        pre = 0;
        post = 4'h0;
      end
      IDX_PERIOD_HIGH: hbuf = d;
      IDX_CTRL_FIRST: begin
        {en, wide, osel} = {d[7], d[4], d[3:0]};
        pre = 0;
        post = 4'h0;
      end
      IDX_CTRL_SECOND: begin
        {code, asy, psel} = d;
        pre = 0;
        post = 4'h0;
      end
      IDX_IRQ_CTRL: {ie, flag} = d[1:0];
      default: ;
    endcase
  endtask : wr

  // one rising edge of the selected source
  task tick;
    logic ev;
    ev = 1'b0;
    if (!en || (sleep && !asy)) return;
    pre++;
    if (pre < (1 << psel)) return;
    pre = 0;
    if (wide) begin
      cnt++;
      ev = (cnt == 16'h0000);
    end else if (cnt[7:0] == buf8) begin
      cnt[7:0] = 8'h00;
      buf8 = hbuf;
      ev = 1'b1;
    end else cnt[7:0]++;
    if (ev) begin
      if (post == osel) begin
        post = 4'h0;
        out = ~out;
        flag = 1'b1;
      end else post++;
    end
  endtask : tick

  // selected source level; the instruction clock is not modelled here
  function logic eff;
    if (code == 3'h2) return 1'b0;
    return src[code < 3'h2 ? 0 : code - 3'h2] ^ (code == 3'h1);
  endfunction : eff

  // slow source edges leave room for the synchroniser latency
  task setsrc(input int i, input logic v);
    logic a;
    a = eff();
    src[i] <= v;
    repeat (8) @(posedge clk);
    if (!a && eff()) tick();
  endtask : setsrc

  task pulse(input int i);
    setsrc(i, ~src[i]);
    setsrc(i, ~src[i]);
  endtask : pulse

  task verify;
    logic [7:0] r;
    bus(IDX_COUNT_LOW, 1'b0, 8'h00, r);
    chk("count low", cnt[7:0], r);
    if (wide) begin
      // the low byte read just refilled the software high byte
      hbuf = cnt[15:8];
      bus(IDX_PERIOD_HIGH, 1'b0, 8'h00, r);
      chk("count high", cnt[15:8], r);
    end
    bus(IDX_CTRL_FIRST, 1'b0, 8'h00, r);
    chk("control first", {en, 1'b0, out, wide, osel}, r);
    bus(IDX_IRQ_CTRL, 1'b0, 8'h00, r);
    chk("irq control", {ie, flag}, r);
    chk("output", out, tout);
    chk("cpu irq", flag & ie, irq);
    chk("wake", flag & ie & sleep & asy, wake);
  endtask : verify

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    verify;
    bus(IDX_CTRL_SECOND, 1'b0, 8'h00, q);
    chk("control second", 16'h0000, q);
    wr(12'h5A1, 8'h5A);
    bus(12'h5A1, 1'b0, 8'h00, q);
    chk("unmapped", 16'h0000, q);
    // 8-bit period match, then a period change that waits for the match
    wr(IDX_PERIOD_HIGH, 8'h03);
    wr(IDX_IRQ_CTRL, 8'h02);
    wr(IDX_CTRL_FIRST, 8'h80);
    repeat (10) pulse(0);
    verify;
    wr(IDX_PERIOD_HIGH, 8'h01);
    repeat (6) pulse(0);
    verify;
    // postscale 1:3; the read-only status bit ignores the write
    wr(IDX_CTRL_FIRST, 8'hA2);
    wr(IDX_IRQ_CTRL, 8'h02);
    repeat (4) begin
      repeat (3) pulse(0);
      verify;
    end
    // prescale 1:4, restarted by a low byte write
    wr(IDX_CTRL_FIRST, 8'h80);
    wr(IDX_CTRL_SECOND, 8'h02);
    repeat (3) pulse(0);
    wr(IDX_COUNT_LOW, 8'h00);
    repeat (9) pulse(0);
    verify;
    // every source code except the instruction clock; others must not count
    for (int c = 0; c < 8; c++) begin
      if (c != 2) begin
        if (c == 1) setsrc(0, 1'b1);
        wr(IDX_CTRL_SECOND, {c[2:0], 5'h00});
        for (int j = 0; j < 6; j++) pulse(j);
        verify;
      end
    end
    setsrc(0, 1'b0);
    // 16-bit wrap and buffered high byte
    wr(IDX_CTRL_FIRST, 8'h90);
    wr(IDX_CTRL_SECOND, 8'h00);
    wr(IDX_PERIOD_HIGH, 8'hFF);
    wr(IDX_COUNT_LOW, 8'hFD);
    repeat (4) pulse(0);
    verify;
    wr(IDX_PERIOD_HIGH, 8'h12);
    verify;
    // the check above latched the live high byte, so buffer it again
    wr(IDX_PERIOD_HIGH, 8'h12);
    wr(IDX_COUNT_LOW, 8'h34);
    verify;
    // disabled timer holds everything
    wr(IDX_CTRL_FIRST, 8'h10);
    repeat (3) pulse(0);
    verify;
    // sleep: synchronous stops, asynchronous counts and wakes
    wr(IDX_CTRL_FIRST, 8'h80);
    wr(IDX_COUNT_LOW, 8'h00);
    sleep <= 1'b1;
    wr(IDX_IRQ_CTRL, 8'h02);
    repeat (3) pulse(0);
    verify;
    wr(IDX_CTRL_SECOND, 8'h10);
    repeat (20) pulse(0);
    verify;
    sleep <= 1'b0;
    // instruction clock: one count per four system clocks
    wr(IDX_CTRL_FIRST, 8'h90);
    wr(IDX_CTRL_SECOND, 8'h40);
    wr(IDX_PERIOD_HIGH, 8'h00);
    wr(IDX_COUNT_LOW, 8'h00);
    repeat (80) @(posedge clk);
    bus(IDX_COUNT_LOW, 1'b0, 8'h00, q);
    chk("instr rate", 16'h0001, {15'h0, q >= 8'h11 && q <= 8'h16});
    give_verdict;
  end
endmodule : timer_with_prescale_postscale_test
